// *** hw/qpd_defs.svh ***
// Register offsets, field positions and reset values of the quadrature position decoder.
// Assumes a 32-bit AHB-Lite register window with word-aligned registers.
`ifndef QPD_DEFS_SVH
`define QPD_DEFS_SVH

`define QPD_ADDR_W          8
`define QPD_CNT_W           16
`define QPD_OFS_CONTROL     8'h00
`define QPD_OFS_FILTER      8'h04
`define QPD_OFS_POSITION    8'h08
`define QPD_OFS_MAXCOUNT    8'h0C
`define QPD_OFS_STATUS      8'h10
`define QPD_CTL_DIRSRC      0
`define QPD_CTL_MODE_LO     8
`define QPD_CTL_MODE_HI     10
`define QPD_CTL_UPSEL       11
`define QPD_FLT_CK_LO       4
`define QPD_FLT_CK_HI       6
`define QPD_FLT_OUTEN       7
`define QPD_STA_MATCH       0
`define QPD_STA_INDEX       1
`define QPD_MODE_TIMER      3'h1
`define QPD_MODE_X2_INDEX   3'h4
`define QPD_MODE_X2_MATCH   3'h5
`define QPD_MODE_X4_INDEX   3'h6
`define QPD_MODE_X4_MATCH   3'h7
`define QPD_MAXCOUNT_RESET  16'hFFFF
`define QPD_FILTER_LEN      3
`define QPD_PRE_W           7
`define QPD_HTRANS_NONSEQ   2'h2

`endif

// *** hw/qpd_pkg.sv ***
// Types shared by the quadrature position decoder.
// Assumes qpd_defs.svh is on the include path.
`include "qpd_defs.svh"

package qpd_pkg;

    typedef enum logic [1:0] {
        OP_OFF,
        OP_TIMER,
        OP_X2,
        OP_X4
    } op_t;

    typedef struct packed {
        logic a;
        logic b;
        logic i;
    } pins_t;

    typedef struct packed {
        logic [2:0]                  sync1;
        logic [2:0]                  sync2;
        logic [2:0][`QPD_FILTER_LEN-1:0] hist;
        logic [2:0]                  filt;
        pins_t                       prev;
        logic [`QPD_PRE_W-1:0]       pre;
        logic [2:0]                  mode;
        logic                        up_sel;
        logic                        dir_src;
        logic                        fout_en;
        logic [2:0]                  ck_div;
        logic [`QPD_CNT_W-1:0]       pos;
        logic [`QPD_CNT_W-1:0]       maxc;
        logic                        flag_match;
        logic                        flag_index;
        logic                        dir;
        logic                        ap_valid;
        logic                        ap_write;
        logic [`QPD_ADDR_W-1:0]      ap_addr;
        logic                        rd_pend;
        logic                        hready;
        logic [31:0]                 hrdata;
    } state_t;

endpackage

// *** hw/quadrature_position_decoder.sv ***
// Quadrature position decoder with x2/x4 counting, noise filters and an alternate timer.
// Assumes an AHB-Lite master on REF_CLK and encoder pins synchronous to REF_CLK.
//
// Overview of operation
// RL1: Mode field sits at control bits 10:8.
// RL2: Modes 100/101 count both phase A edges.
// RL3: Mode 100 clears count on index pulse.
// RL4: Mode 101 clears count on maximum match.
// RL5: Modes 110/111 count every A, B edge.
// RL6: Mode 110 clears count on index pulse.
// RL7: Mode 111 clears count on maximum match.
// RL8: Filter output follows three stable samples only.
// RL9: Filter clock divider chosen by bits 6:4.
// RL10: Filtered inputs used only when enabled.
// RL11: Filters start disabled after reset.
// RL12: Mode 001 is a timer clocked by A.
// RL13: Timer uses position/maximum; match sets flag.
// RL14: High direction input counts up, low down.
// RL15: Control bit 11 selects timer direction.
// RL16: Control bit 0 picks phase B direction.
// RL17: Mode changes never alter the count.
// RL18: Timer clock resynchronised to the core clock.
// RL19: Sleep halts all counting and decoding.
// RL20: A leading B counts up, else down.
// RL21: Count resets load zero; reset clears all except the maximum (loads MAX_RESET) and HREADYOUT (set).
`timescale 1ns/1ns

module quadrature_position_decoder
    import qpd_pkg::*;
#(
    parameter logic [`QPD_CNT_W-1:0] MAX_RESET = `QPD_MAXCOUNT_RESET
) (
    input  wire logic                   REF_CLK,
    input  wire logic                   RST_N,
    input  wire logic                   CE,
    input  wire logic                   SLEEP,
    input  wire logic                   PHASE_A_INPUT,
    input  wire logic                   PHASE_B_INPUT,
    input  wire logic                   INDEX_INPUT,
    input  wire logic                   HSEL,
    input  wire logic [31:0]            HADDR,
    input  wire logic [1:0]             HTRANS,
    input  wire logic                   HWRITE,
    input  wire logic [2:0]             HSIZE,
    input  wire logic [31:0]            HWDATA,
    input  wire logic                   HREADY,
    output logic      [31:0]            HRDATA,
    output logic                        HREADYOUT,
    output logic                        HRESP,
    output logic      [`QPD_CNT_W-1:0]  POSITION_COUNT,
    output logic                        MATCH_FLAG,
    output logic                        INDEX_FLAG,
    output logic                        COUNT_DIRECTION
);

    state_t s_r;
    state_t s_nxt;

    // Maps the mode field onto the kind of operation.
    function automatic op_t op_of(input logic [2:0] m);
        case (m)
            `QPD_MODE_TIMER:    op_of = OP_TIMER;
            `QPD_MODE_X2_INDEX,
            `QPD_MODE_X2_MATCH: op_of = OP_X2;
            `QPD_MODE_X4_INDEX,
            `QPD_MODE_X4_MATCH: op_of = OP_X4;
            default:            op_of = OP_OFF;
        endcase
    endfunction

    // Forms the read word of a register; unmapped offsets read as zero.
    function automatic logic [31:0] reg_read(input logic [`QPD_ADDR_W-1:0] a,
                                             input state_t st);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            `QPD_OFS_CONTROL: begin
                w[`QPD_CTL_MODE_HI:`QPD_CTL_MODE_LO] = st.mode;
                w[`QPD_CTL_UPSEL]  = st.up_sel;
                w[`QPD_CTL_DIRSRC] = st.dir_src;
            end
            `QPD_OFS_FILTER: begin
                w[`QPD_FLT_CK_HI:`QPD_FLT_CK_LO] = st.ck_div;
                w[`QPD_FLT_OUTEN] = st.fout_en;
            end
            `QPD_OFS_POSITION: w[`QPD_CNT_W-1:0] = st.pos;
            `QPD_OFS_MAXCOUNT: w[`QPD_CNT_W-1:0] = st.maxc;
            `QPD_OFS_STATUS: begin
                w[`QPD_STA_MATCH] = st.flag_match;
                w[`QPD_STA_INDEX] = st.flag_index;
            end
            default: w = 32'h0000_0000;
        endcase
        reg_read = w;
    endfunction

    always_comb begin
        op_t                    op;
        logic                   tick;
        logic [`QPD_PRE_W-1:0]  pre_top;
        logic [2:0]             hnew;
        pins_t                  sel;
        logic                   a_edge;
        logic                   b_edge;
        logic                   i_rise;
        logic                   step;
        logic                   up;
        logic                   use_match;
        logic                   index_mode;
        logic                   set_match;
        logic                   set_index;
        logic                   clr_match;
        logic                   clr_index;
        logic                   wr;
        s_nxt      = s_r;
        op         = op_of(s_r.mode);
        tick       = 1'b0;
        pre_top    = '0;
        hnew       = '0;
        sel        = '0;
        a_edge     = 1'b0;
        b_edge     = 1'b0;
        i_rise     = 1'b0;
        step       = 1'b0;
        up         = 1'b0;
        use_match  = 1'b0;
        index_mode = 1'b0;
        set_match  = 1'b0;
        set_index  = 1'b0;
        clr_match  = 1'b0;
        clr_index  = 1'b0;
        wr         = 1'b0;
        if (CE) begin
            // Two-stage resynchroniser for all encoder pins. [RL18]
            s_nxt.sync1 = {PHASE_A_INPUT, PHASE_B_INPUT, INDEX_INPUT};
            s_nxt.sync2 = s_r.sync1;

            if (!SLEEP) begin // [RL19]
                // Filter clock is the core clock divided by 2 to the power of the field. [RL9]
                pre_top = `QPD_PRE_W'((1 << s_r.ck_div) - 1);
                tick    = (s_r.pre >= pre_top);
                s_nxt.pre = tick ? '0 : s_r.pre + `QPD_PRE_W'(1);
                for (int c = 0; c < 3; c++) begin
                    if (tick) begin
                        hnew = {s_r.hist[c][`QPD_FILTER_LEN-2:0], s_r.sync2[c]};
                        s_nxt.hist[c] = hnew;
                        if (&hnew || ~|hnew) begin
                            s_nxt.filt[c] = hnew[0]; // [RL8]
                        end
                    end
                end

                // Filtered pins replace raw ones only when enabled. [RL10]
                sel = s_r.fout_en ? pins_t'(s_r.filt) : pins_t'(s_r.sync2);
                s_nxt.prev = sel;
                a_edge = sel.a ^ s_r.prev.a;
                b_edge = sel.b ^ s_r.prev.b;
                i_rise = sel.i & ~s_r.prev.i;
                index_mode = ~s_r.mode[0];

                case (op)
                    OP_X2: begin
                        step = a_edge & ~b_edge; // [RL2]
                        up   = sel.a ^ s_r.prev.b; // [RL20]
                    end
                    OP_X4: begin
                        step = a_edge ^ b_edge; // [RL5]
                        up   = sel.a ^ s_r.prev.b; // [RL20]
                    end
                    OP_TIMER: begin
                        step = a_edge & sel.a; // [RL12]
                        up   = s_r.dir_src ? sel.b : s_r.up_sel; // [RL14] [RL15] [RL16]
                        index_mode = 1'b0;
                    end
                    default: begin
                        step = 1'b0;
                        up   = 1'b0;
                    end
                endcase
                use_match = (op == OP_TIMER) | s_r.mode[0];

                if ((op == OP_X2 || op == OP_X4) && index_mode && i_rise) begin
                    s_nxt.pos = '0; // [RL3] [RL6] [RL21]
                    set_index = 1'b1;
                end else if (step) begin
                    if (up) begin
                        if (use_match && s_r.pos == s_r.maxc) begin
                            s_nxt.pos = '0; // [RL4] [RL7] [RL13] [RL21]
                            set_match = 1'b1;
                        end else begin
                            s_nxt.pos = s_r.pos + `QPD_CNT_W'(1);
                        end
                    end else begin
                        if (use_match && s_r.pos == '0) begin
                            s_nxt.pos = s_r.maxc; // [RL13]
                            set_match = 1'b1;
                        end else begin
                            s_nxt.pos = s_r.pos - `QPD_CNT_W'(1);
                        end
                    end
                end
                if (step && op != OP_TIMER) begin
                    s_nxt.dir = up;
                end
            end

            // Bus data phase: writes land here; mode writes leave the count alone. [RL17]
            wr = s_r.ap_valid & s_r.ap_write;
            if (wr) begin
                case (s_r.ap_addr)
                    `QPD_OFS_CONTROL: begin
                        s_nxt.mode    = HWDATA[`QPD_CTL_MODE_HI:`QPD_CTL_MODE_LO]; // [RL1]
                        s_nxt.up_sel  = HWDATA[`QPD_CTL_UPSEL];
                        s_nxt.dir_src = HWDATA[`QPD_CTL_DIRSRC];
                    end
                    `QPD_OFS_FILTER: begin
                        s_nxt.ck_div  = HWDATA[`QPD_FLT_CK_HI:`QPD_FLT_CK_LO];
                        s_nxt.fout_en = HWDATA[`QPD_FLT_OUTEN];
                    end
                    `QPD_OFS_POSITION: s_nxt.pos  = HWDATA[`QPD_CNT_W-1:0];
                    `QPD_OFS_MAXCOUNT: s_nxt.maxc = HWDATA[`QPD_CNT_W-1:0];
                    `QPD_OFS_STATUS: begin
                        clr_match = HWDATA[`QPD_STA_MATCH];
                        clr_index = HWDATA[`QPD_STA_INDEX];
                    end
                    default: s_nxt.mode = s_r.mode;
                endcase
            end
            // A new event outranks a clear in the same cycle.
            s_nxt.flag_match = (s_r.flag_match & ~clr_match) | set_match;
            s_nxt.flag_index = (s_r.flag_index & ~clr_index) | set_index;

            // Reads take one wait state so that a preceding write is seen.
            s_nxt.ap_valid = 1'b0;
            if (s_r.rd_pend) begin
                s_nxt.hrdata  = reg_read(s_r.ap_addr, s_r);
                s_nxt.rd_pend = 1'b0;
                s_nxt.hready  = 1'b1;
            end else if (HSEL && HREADY && HTRANS == `QPD_HTRANS_NONSEQ) begin
                s_nxt.ap_addr  = HADDR[`QPD_ADDR_W-1:0];
                s_nxt.ap_write = HWRITE;
                s_nxt.ap_valid = HWRITE;
                s_nxt.rd_pend  = ~HWRITE;
                s_nxt.hready   = HWRITE;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_r         <= '0; // [RL11] [RL21]
            s_r.maxc    <= MAX_RESET;
            s_r.hready  <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign HRDATA          = s_r.hrdata;
    assign HREADYOUT       = s_r.hready;
    assign HRESP           = 1'b0;
    assign POSITION_COUNT  = s_r.pos;
    assign MATCH_FLAG      = s_r.flag_match;
    assign INDEX_FLAG      = s_r.flag_index;
    assign COUNT_DIRECTION = s_r.dir;

endmodule

// *** verification/qenc_model.sv ***
// Behavioural incremental encoder with an index output.
// Assumes its inputs change just after rising edges of clk.
`timescale 1ns/1ns
module qenc_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic step,
    input  wire logic dir,
    input  wire logic idx_req,
    input  wire logic glitch,
    output logic      a,
    output logic      b,
    output logic      idx
);
    logic [1:0] ph_r;
    logic       idx_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_r  <= 2'h0;
            idx_r <= 1'b0;
        end else begin
            if (step) begin
                ph_r <= dir ? ph_r + 2'h1 : ph_r - 2'h1;
            end
            idx_r <= idx_req;
        end
    end
    assign a   = (ph_r == 2'h1) || (ph_r == 2'h2);
    assign b   = ph_r[1];
    assign idx = idx_r ^ glitch;
endmodule

// *** verification/qpd_chk.sv ***
// Concurrent checks on the ports of the quadrature position decoder.
// Assumes one REF_CLK domain with RST_N as its asynchronous reset.
`timescale 1ns/1ns
module qpd_chk (
    input wire logic        REF_CLK,
    input wire logic        RST_N,
    input wire logic        CE,
    input wire logic        SLEEP,
    input wire logic        HSEL,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic        HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    input wire logic [15:0] POSITION_COUNT,
    input wire logic        MATCH_FLAG,
    input wire logic        INDEX_FLAG
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    logic tk;
    logic wr_r;
    assign tk = CE && HSEL && HREADY && (HTRANS == 2'h2);
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_r <= 1'b0;
        end else if (CE) begin
            wr_r <= tk && HWRITE;
        end
    end
    property p_okay;
        HRESP == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("response not OKAY");
    property p_rd_wait;
        (tk && !HWRITE) ##1 CE |-> !HREADYOUT ##1 HREADYOUT;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait not one cycle");
    property p_wr_fast;
        tk && HWRITE |=> HREADYOUT;
    endproperty
    a_wr_fast: assert property (p_wr_fast) else $error("write inserted a wait");
    property p_rdata;
        !$rose(HREADYOUT) |-> $stable(HRDATA);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data moved");
    property p_freeze;
        !CE |=> $stable(POSITION_COUNT) && $stable(HREADYOUT) && $stable(MATCH_FLAG);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved without enable");
    property p_sleep;
        SLEEP && CE && !wr_r |=> $stable(POSITION_COUNT);
    endproperty
    a_sleep: assert property (p_sleep) else $error("count moved in sleep");
    property p_index;
        $rose(INDEX_FLAG) |-> POSITION_COUNT == 16'h0000;
    endproperty
    a_index: assert property (p_index) else $error("index did not clear count");
    property p_reset;
        $rose(RST_N) |-> POSITION_COUNT == 16'h0000 && !MATCH_FLAG && !INDEX_FLAG && HREADYOUT;
    endproperty
    a_reset: assert property (p_reset) else $error("bad state after reset");
endmodule
bind quadrature_position_decoder qpd_chk u_chk (.REF_CLK(REF_CLK), .RST_N(RST_N), .CE(CE),
    .SLEEP(SLEEP), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .POSITION_COUNT(POSITION_COUNT),
    .MATCH_FLAG(MATCH_FLAG), .INDEX_FLAG(INDEX_FLAG));

// *** verification/quadrature_position_decoder_tb.sv ***
// Self-checking bench for the quadrature position decoder.
// Assumes the encoder model drives the pins and the bench is the only bus master.
`timescale 1ns/1ns
module quadrature_position_decoder_tb
    import qpd_pkg::*;
;
    logic        REF_CLK = 1'b0;
    logic        RST_N   = 1'b0;
    logic        CE      = 1'b1;
    logic        SLEEP   = 1'b0;
    logic        HWRITE  = 1'b0;
    logic [1:0]  HTRANS  = 2'h0;
    logic [31:0] HADDR   = 32'h0;
    logic [31:0] HWDATA  = 32'h0;
    logic        step    = 1'b0;
    logic        dir     = 1'b0;
    logic        idx_req = 1'b0;
    logic        glitch  = 1'b0;
    wire  [31:0] HRDATA;
    wire  [15:0] POSITION_COUNT;
    wire         HREADYOUT, HRESP, MATCH_FLAG, INDEX_FLAG, COUNT_DIRECTION, pa, pb, pi;
    int          n_mismatch   = 0;
    int          total_checks = 0;
    logic [31:0] rd;
    qenc_model enc (.clk(REF_CLK), .rst_n(RST_N), .step(step), .dir(dir), .idx_req(idx_req),
        .glitch(glitch), .a(pa), .b(pb), .idx(pi));
    quadrature_position_decoder dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .CE(CE), .SLEEP(SLEEP),
        .PHASE_A_INPUT(pa), .PHASE_B_INPUT(pb), .INDEX_INPUT(pi), .HSEL(1'b1), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .POSITION_COUNT(POSITION_COUNT),
        .MATCH_FLAG(MATCH_FLAG), .INDEX_FLAG(INDEX_FLAG), .COUNT_DIRECTION(COUNT_DIRECTION));
    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] want);
        total_checks++;
        if (got !== want) begin
            n_mismatch++;
            $display("BAD %0t got %h want %h", $time, got, want);
        end
    endtask
    task wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge REF_CLK);
            n++;
        end while (HREADYOUT !== 1'b1 && n < 50);
        if (HREADYOUT !== 1'b1) begin
            n_mismatch++;
            $display("BAD %0t bus hang", $time);
            report_and_stop;
        end
    endtask
    task bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        HTRANS <= 2'h2;
        HADDR  <= {24'h0, ad};
        HWRITE <= w;
        wait_rdy;
        HTRANS <= 2'h0;
        HWDATA <= wd;
        wait_rdy;
        rd = HRDATA;
    endtask
    task rdc(input logic [7:0] ad, input logic [31:0] want);
        bus(1'b0, ad, 32'h0);
        chk(rd, want);
    endtask
    task steps(input int n, input logic d);
        repeat (n) begin
            step <= 1'b1;
            dir  <= d;
            @(posedge REF_CLK);
            step <= 1'b0;
            repeat (11) @(posedge REF_CLK);
        end
    endtask
    task pulse(input int n, input logic g);
        if (g) glitch <= 1'b1; else idx_req <= 1'b1;
        repeat (n) @(posedge REF_CLK);
        glitch  <= 1'b0;
        idx_req <= 1'b0;
        repeat (40) @(posedge REF_CLK);
    endtask
    initial begin
        forever #5 REF_CLK = ~REF_CLK;
    end
    initial begin
        repeat (12) @(posedge REF_CLK);
        RST_N <= 1'b1;
        @(posedge REF_CLK);
        rdc(8'h00, 32'h0);
        rdc(8'h04, 32'h0);
        rdc(8'h0C, 32'hFFFF);
        rdc(8'h20, 32'h0);
        chk(POSITION_COUNT, 32'h0);
        $display("reset test done");
        bus(1'b1, 8'h00, 32'h600);
        steps(6, 1'b1);
        chk(POSITION_COUNT, 32'h6);
        chk(COUNT_DIRECTION, 32'h1);
        steps(2, 1'b0);
        chk(POSITION_COUNT, 32'h4);
        chk(COUNT_DIRECTION, 32'h0);
        pulse(1, 1'b0);
        chk(POSITION_COUNT, 32'h0);
        chk(INDEX_FLAG, 32'h1);
        bus(1'b1, 8'h10, 32'h3);
        rdc(8'h10, 32'h0);
        bus(1'b1, 8'h00, 32'h400);
        steps(4, 1'b1);
        chk(POSITION_COUNT, 32'h2);
        pulse(1, 1'b0);
        chk(POSITION_COUNT, 32'h0);
        bus(1'b1, 8'h10, 32'h3);
        $display("measure test done");
        for (int m = 0; m < 2; m++) begin
            bus(1'b1, 8'h0C, m ? 32'h3 : 32'h1);
            bus(1'b1, 8'h08, 32'h0);
            bus(1'b1, 8'h00, m ? 32'h700 : 32'h500);
            steps(4, 1'b1);
            chk(POSITION_COUNT, 32'h0);
            chk(MATCH_FLAG, 32'h1);
            bus(1'b1, 8'h10, 32'h1);
        end
        $display("match test done");
        bus(1'b1, 8'h00, 32'h600);
        SLEEP <= 1'b1;
        steps(4, 1'b1);
        SLEEP <= 1'b0;
        CE    <= 1'b0;
        steps(4, 1'b1);
        CE    <= 1'b1;
        chk(POSITION_COUNT, 32'h0);
        bus(1'b1, 8'h00, 32'h200);
        steps(4, 1'b1);
        chk(POSITION_COUNT, 32'h0);
        $display("sleep test done");
        bus(1'b1, 8'h0C, 32'hFFFF);
        bus(1'b1, 8'h08, 32'h5);
        bus(1'b1, 8'h00, 32'h900);
        chk(POSITION_COUNT, 32'h5);
        steps(4, 1'b1);
        chk(POSITION_COUNT, 32'h6);
        bus(1'b1, 8'h00, 32'h901);
        steps(4, 1'b1);
        chk(POSITION_COUNT, 32'h5);
        bus(1'b1, 8'h00, 32'h600);
        chk(POSITION_COUNT, 32'h5);
        bus(1'b1, 8'h00, 32'h100);
        steps(4, 1'b1);
        chk(POSITION_COUNT, 32'h4);
        bus(1'b1, 8'h0C, 32'h4);
        bus(1'b1, 8'h00, 32'h900);
        steps(4, 1'b1);
        chk(POSITION_COUNT, 32'h0);
        chk(MATCH_FLAG, 32'h1);
        bus(1'b1, 8'h08, 32'h5);
        bus(1'b1, 8'h00, 32'h600);
        chk(POSITION_COUNT, 32'h5);
        $display("timer test done");
        bus(1'b1, 8'h04, 32'h80);
        pulse(1, 1'b1);
        chk(POSITION_COUNT, 32'h5);
        bus(1'b1, 8'h04, 32'hB0);
        pulse(4, 1'b1);
        chk(POSITION_COUNT, 32'h5);
        bus(1'b1, 8'h04, 32'h30);
        pulse(1, 1'b1);
        chk(POSITION_COUNT, 32'h0);
        $display("filter test done");
        report_and_stop;
    end
endmodule
